// ===== rlmu_core.v
// Data-register load and arithmetic/logic unit with buffered command queue
`timescale 1ns/1ps
`default_nettype none
`include "rlmu_defines.vh"

module rlmu_core #(
    // Queue depth; QAW must be the log2 of QDEPTH
    parameter QDEPTH = 4,
    parameter QAW = 2,
    // One bit per register: short registers, then read-only registers
    parameter [31:0] SHORT_MASK = 32'hFFFF0000,
    parameter [31:0] RO_MASK = 32'hF0000000
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata_ff,
    // Condition flags toward the conditional_jump logic
    output reg [4:0] cond_flags_ff,
    // Pulse each time a queued command finishes
    output reg cmd_done_ff
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Sign-extend a short register so math and read-back see a signed value
    function [31:0] rlmu_view;
        input [4:0] idx;
        input [31:0] val;
        begin
            if (SHORT_MASK[idx])
                rlmu_view = {{16{val[15]}}, val[15:0]};
            else
                rlmu_view = val;
        end
    endfunction

    // Flags from a math result
    function [4:0] rlmu_flags;
        input [31:0] res;
        reg is_zero;
        begin
            is_zero = (res == `RLMU_ZERO32);
            rlmu_flags = 5'h00;
            rlmu_flags[`RLMU_CC_Z] = is_zero;
            rlmu_flags[`RLMU_CC_N] = res[31];
            rlmu_flags[`RLMU_CC_P] = ~res[31] & ~is_zero;
            rlmu_flags[`RLMU_CC_T] = ~is_zero;
            rlmu_flags[`RLMU_CC_F] = is_zero;
        end
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [31:0] regs_ff [0:31];  // Data registers, index 0 is the accumulator
    reg [31:0] value_ff;        // Staged immediate value
    reg [2:0] q_op_ff [0:QDEPTH-1];
    reg [4:0] q_a_ff [0:QDEPTH-1];
    reg [4:0] q_b_ff [0:QDEPTH-1];
    reg q_hv_ff [0:QDEPTH-1];
    reg [31:0] q_val_ff [0:QDEPTH-1];
    reg [QAW-1:0] wr_ptr_ff;
    reg [QAW-1:0] rd_ptr_ff;
    reg [QAW:0] count_ff;       // Entries held, one bit wider than the pointers
    reg [31:0] readback_ff;     // Last read-back value
    reg rb_valid_ff;            // Sticky: read-back value waiting
    reg range_err_ff;           // Sticky: load value out of long range
    reg ro_err_ff;              // Sticky: write attempt on read-only register
    reg ovfl_ff;                // Sticky: command dropped, queue full

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // The port pushes at most one command a cycle and the head pops each
    // cycle, so the queue only backs up if execution is ever held off
    wire q_full = (count_ff == QDEPTH[QAW:0]);
    wire q_empty = (count_ff == {(QAW+1){1'b0}});
    wire push_req = wr_stb && (addr == `RLMU_OFS_CMD);
    wire push = push_req && !q_full;
    wire pop = !q_empty;  // One command executes per cycle
    wire st_wr = wr_stb && (addr == `RLMU_OFS_STATUS);
    wire rb_rd = rd_stb && (addr == `RLMU_OFS_READBACK);

    // Head of queue
    wire [2:0] h_op = q_op_ff[rd_ptr_ff];
    wire [4:0] h_a = q_a_ff[rd_ptr_ff];
    wire [4:0] h_b = q_b_ff[rd_ptr_ff];
    wire h_hv = q_hv_ff[rd_ptr_ff];
    wire [31:0] h_val = q_val_ff[rd_ptr_ff];

    // Short operands are sign-extended before any arithmetic
    // Operands may be any register, read-only included
    wire [31:0] opa = rlmu_view(h_a, regs_ff[h_a]);
    wire [31:0] opb = rlmu_view(h_b, regs_ff[h_b]);

    // ----------------------------------------
    // Arithmetic and logic
    // ----------------------------------------
    reg [31:0] math_res;  // Result bound for the accumulator
    reg math_we;          // Accumulator and flags update
    // A full-width product costs area; only its low word is ever used
    reg [63:0] prod;      // Full product, only low word kept

    // Sums wrap modulo 2^32 with no overflow flag
    always @*
    begin
        math_res = `RLMU_ZERO32;
        math_we = 1'b0;
        prod = $signed(opa) * $signed(opb);
        if (pop)
        begin
            case (h_op)
                `RLMU_OP_ADD:
                begin
                    math_res = opa + opb;
                    math_we = 1'b1;
                end
                `RLMU_OP_SUB:
                begin
                    math_res = opa - opb;
                    math_we = 1'b1;
                end
                `RLMU_OP_MUL:
                begin
                    math_res = prod[31:0];
                    math_we = 1'b1;
                end
                `RLMU_OP_DIV:
                begin
                    // Zero divisor: no result and no flag change
                    if (opb != `RLMU_ZERO32)
                    begin
                        math_res = $signed(opa) / $signed(opb);
                        math_we = 1'b1;
                    end
                end
                `RLMU_OP_AND:
                begin
                    math_res = opa & opb;
                    math_we = 1'b1;
                end
                default:
                begin
                    // Unused opcodes touch no accumulator; a load writes it only when aimed at register 0
                    math_res = `RLMU_ZERO32;
                    math_we = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Load decode
    // ----------------------------------------
    // Refused loads still retire, so cmd_done_ff stays one per command
    wire is_load = pop && (h_op == `RLMU_OP_LOAD);
    wire ld_read = is_load && !h_hv;
    wire ld_bad_range = (h_val == `RLMU_LONG_ILLEGAL);
    wire ld_bad_ro = RO_MASK[h_a];
    wire ld_write = is_load && h_hv && !ld_bad_range && !ld_bad_ro;

    // ----------------------------------------
    // Command queue
    // ----------------------------------------

    // Commands are queued so a stored sequence runs in order
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_ptr_ff <= {QAW{1'b0}};
            rd_ptr_ff <= {QAW{1'b0}};
            count_ff <= {(QAW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                q_op_ff[wr_ptr_ff] <= wdata[`RLMU_CMD_OP_MSB:`RLMU_CMD_OP_LSB];
                q_a_ff[wr_ptr_ff] <= wdata[`RLMU_CMD_A_MSB:`RLMU_CMD_A_LSB];
                q_b_ff[wr_ptr_ff] <= wdata[`RLMU_CMD_B_MSB:`RLMU_CMD_B_LSB];
                q_hv_ff[wr_ptr_ff] <= wdata[`RLMU_CMD_HASVAL_BIT];
                q_val_ff[wr_ptr_ff] <= value_ff;
                wr_ptr_ff <= wr_ptr_ff + {{(QAW-1){1'b0}}, 1'b1};
            end
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + {{(QAW-1){1'b0}}, 1'b1};
            // Push and pop in one cycle leave the count alone
            if (push && !pop)
                count_ff <= count_ff + {{QAW{1'b0}}, 1'b1};
            else if (pop && !push)
                count_ff <= count_ff - {{QAW{1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------
    // Data register file
    // ----------------------------------------
    // Loop index for the reset sweep of the register file
    integer i;

    // Read-only registers are never written, so they always read zero
    // Loads and math results share the file; a load to register zero and
    // a math op cannot coincide since only one command runs per cycle
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            for (i = 0; i < 32; i = i + 1)
                regs_ff[i] <= `RLMU_ZERO32;
        end
        else if (ld_write)
        begin
            // Short targets keep only the low half
            if (SHORT_MASK[h_a])
                regs_ff[h_a] <= {16'h0000, h_val[15:0]};
            else
                regs_ff[h_a] <= h_val;
        end
        else if (math_we)
            regs_ff[`RLMU_ACC_IDX] <= math_res;
    end

    // ----------------------------------------
    // Flags, read-back and sticky status
    // ----------------------------------------

    // Status bits: hardware set wins over a software clear in the same cycle
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            value_ff <= `RLMU_ZERO32;
            cond_flags_ff <= `RLMU_CC_RESET;
            readback_ff <= `RLMU_ZERO32;
            rb_valid_ff <= 1'b0;
            range_err_ff <= 1'b0;
            ro_err_ff <= 1'b0;
            ovfl_ff <= 1'b0;
            cmd_done_ff <= 1'b0;
        end
        else
        begin
            // Skipped divides and refused loads also report completion
            cmd_done_ff <= pop;
            // The staged value is copied into the queue when CMD is written
            if (wr_stb && (addr == `RLMU_OFS_VALUE))
                value_ff <= wdata;
            // Each math op that yields a result refreshes the flags
            if (math_we)
                cond_flags_ff <= rlmu_flags(math_res);
            // No value given: return contents instead of writing
            if (ld_read)
            begin
                readback_ff <= rlmu_view(h_a, regs_ff[h_a]);
                rb_valid_ff <= 1'b1;
            end
            else if (rb_rd)
                rb_valid_ff <= 1'b0;
            // Long range check on every valued load
            if (is_load && h_hv && ld_bad_range)
                range_err_ff <= 1'b1;
            else if (st_wr && wdata[`RLMU_ST_RANGE_ERR_BIT])
                range_err_ff <= 1'b0;
            // Read-only registers accept only read-back
            if (is_load && h_hv && ld_bad_ro && !ld_bad_range)
                ro_err_ff <= 1'b1;
            else if (st_wr && wdata[`RLMU_ST_RO_ERR_BIT])
                ro_err_ff <= 1'b0;
            // A full queue drops the command rather than stall the port
            if (push_req && q_full)
                ovfl_ff <= 1'b1;
            else if (st_wr && wdata[`RLMU_ST_OVFL_BIT])
                ovfl_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Status is built live so a read sees the current queue state
    reg [31:0] rd_mux;  // Next read data

    // Unmapped offsets answer zero
    always @*
    begin
        rd_mux = `RLMU_ZERO32;
        case (addr)
            `RLMU_OFS_VALUE: rd_mux = value_ff;
            `RLMU_OFS_STATUS:
            begin
                rd_mux[`RLMU_ST_EMPTY_BIT] = q_empty;
                rd_mux[`RLMU_ST_FULL_BIT] = q_full;
                rd_mux[`RLMU_ST_RBVALID_BIT] = rb_valid_ff;
                rd_mux[`RLMU_ST_RANGE_ERR_BIT] = range_err_ff;
                rd_mux[`RLMU_ST_RO_ERR_BIT] = ro_err_ff;
                rd_mux[`RLMU_ST_OVFL_BIT] = ovfl_ff;
                // Flags sit in their own byte so software can test them alone
                rd_mux[`RLMU_ST_CC_MSB:`RLMU_ST_CC_LSB] = cond_flags_ff;
            end
            `RLMU_OFS_READBACK: rd_mux = readback_ff;
            `RLMU_OFS_ACC: rd_mux = regs_ff[`RLMU_ACC_IDX];
            default: rd_mux = `RLMU_ZERO32;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    // Zero outside the read cycle keeps stale data from looking fresh
    always @(posedge core_clk)
    begin
        if (rst)
            rdata_ff <= `RLMU_ZERO32;
        else if (rd_stb)
            rdata_ff <= rd_mux;
        else
            rdata_ff <= `RLMU_ZERO32;
    end

endmodule // rlmu_core

`default_nettype wire

// ===== rlmu_core_monitor.sv
// Port checker for the load/math unit
`timescale 1ns/1ps
`default_nettype none
`include "rlmu_defines.vh"
module rlmu_core_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata_ff,
    // Results
    input wire logic [4:0] cond_flags_ff,
    input wire logic cmd_done_ff
);
    // --------------------------------
    // Outstanding command count
    // --------------------------------
    logic [3:0] pend_ff; // Tests never overfill the queue, so no drops are modelled
    logic push;
    logic math;
    assign push = wr_stb && (addr == `RLMU_OFS_CMD);
    // Ops that always give a result; divide may be skipped, loads and 6/7 do nothing
    assign math = (wdata[2:0] != `RLMU_OP_LOAD) && (wdata[2:0] != `RLMU_OP_DIV)
        && (wdata[2:0] <= `RLMU_OP_AND);
    // Count pushes in, completions out
    always @(posedge core_clk)
    begin
        if (rst)
            pend_ff <= 4'h0;
        else
            pend_ff <= pend_ff + {3'h0, push} - {3'h0, cmd_done_ff};
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_TF_FOLLOWS_Z: assert property (
        cond_flags_ff != 5'h00 |-> (cond_flags_ff[4] != cond_flags_ff[0]) && (cond_flags_ff[3] == cond_flags_ff[0]))
        else $error("true/false flags disagree with zero flag");
    AST_SIGN_ONEHOT: assert property (
        cond_flags_ff != 5'h00 |-> $onehot(cond_flags_ff[2:0]))
        else $error("zero/positive/negative flags not exclusive");
    AST_FLAGS_ON_DONE: assert property (
        !$stable(cond_flags_ff) |-> cmd_done_ff)
        else $error("flags moved without a finished command");
    AST_DONE_LATENCY: assert property (
        push && pend_ff == 4'h0 |-> ##2 cmd_done_ff)
        else $error("idle command not finished two cycles after push");
    AST_DONE_HAS_CAUSE: assert property (
        cmd_done_ff |-> pend_ff != 4'h0)
        else $error("completion without a pushed command");
    AST_LOAD_KEEPS_FLAGS: assert property (
        push && pend_ff == 4'h0 && wdata[2:0] == `RLMU_OP_LOAD |-> ##2 $stable(cond_flags_ff))
        else $error("load changed the flags");
    AST_MATH_SETS_FLAGS: assert property (
        push && pend_ff == 4'h0 && math |-> ##2 $onehot(cond_flags_ff[2:0]))
        else $error("math op left no condition");
    AST_RDATA_IDLE: assert property (
        !$past(rd_stb) |-> rdata_ff == 32'h00000000)
        else $error("read data outside its cycle");
    AST_STATUS_FLAGS: assert property (
        rd_stb && addr == `RLMU_OFS_STATUS |=> rdata_ff[12:8] == $past(cond_flags_ff))
        else $error("status flags differ from flag port");
    COV_MATH: cover property (push && math);
    COV_B2B: cover property (cmd_done_ff ##1 cmd_done_ff);
    COV_ACC: cover property (rd_stb && addr == `RLMU_OFS_ACC);
endmodule // rlmu_core_monitor
bind rlmu_core rlmu_core_monitor i_mon (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
    .cond_flags_ff(cond_flags_ff), .cmd_done_ff(cmd_done_ff));
`default_nettype wire

// ===== rlmu_core_tb_top.sv
// Self-checking bench for the load/math unit
`timescale 1ns/1ps
`default_nettype none
`include "rlmu_defines.vh"
module rlmu_core_tb_top;
    logic core_clk;
    logic rst;
    wire [7:0] addr;
    wire [31:0] wdata;
    wire wr_stb;
    wire rd_stb;
    wire [31:0] rdata_ff;
    wire [4:0] cond_flags_ff;
    wire cmd_done_ff;
    logic [31:0] regs [0:31]; // Expected register file
    logic [31:0] rv;
    logic [4:0] ef; // Expected flags
    int mismatches;
    int samples_checked;
    int done_cnt;
    int base;
    int i;
    rlmu_core i_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
        .cond_flags_ff(cond_flags_ff), .cmd_done_ff(cmd_done_ff));
    rlmu_host_model i_host (.core_clk(core_clk), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff));
    // ----------------------------
    // Clock, completion count, helpers
    // ----------------------------
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
        done_cnt <= rst ? 0 : done_cnt + int'(cmd_done_ff);
    // Short registers sign-extend when used
    function automatic logic [31:0] opnd(input logic [4:0] r);
        opnd = (r >= 5'h10) ? {{16{regs[r][15]}}, regs[r][15:0]} : regs[r];
    endfunction
    function automatic logic [4:0] flg(input logic [31:0] v);
        flg = {v != 0, v == 0, v[31], !v[31] && v != 0, v == 0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    end
    endtask
    // Bounded wait so a lost completion cannot hang the run
    task automatic wait_done(input int tgt);
        int k;
    begin
        for (k = 0; k < 20 && done_cnt < tgt; k++)
        begin
            @(posedge core_clk);
            #1;
        end
        chk(32'(done_cnt >= tgt), 32'h1, "command never finished");
    end
    endtask
    // Load or read back one register, updating the model
    task automatic load(input logic [4:0] r, input logic hv, input logic [31:0] v);
    begin
        if (v == `RLMU_LONG_ILLEGAL)
            v = 32'h80000001; // The host keeps values in range
        base = done_cnt;
        i_host.cmd(`RLMU_OP_LOAD, r, 5'h00, hv, v);
        if (hv && r < 5'h1C) // Read-only targets keep their value
            regs[r] = (r >= 5'h10) ? {16'h0000, v[15:0]} : v;
        wait_done(base + 1);
        if (!hv)
        begin
            i_host.rd(`RLMU_OFS_READBACK, rv);
            chk(rv, opnd(r), "readback");
        end
    end
    endtask
    // Math op against the model; zero divisor leaves everything as it was
    task automatic do_math(input logic [2:0] o, input logic [4:0] a, input logic [4:0] b);
    begin
        if (!(o == `RLMU_OP_DIV && opnd(b) == 32'h0))
        begin
            case (o)
                `RLMU_OP_ADD: regs[0] = opnd(a) + opnd(b);
                `RLMU_OP_SUB: regs[0] = opnd(a) - opnd(b);
                `RLMU_OP_MUL: regs[0] = opnd(a) * opnd(b);
                `RLMU_OP_DIV: regs[0] = $signed(opnd(a)) / $signed(opnd(b));
                default: regs[0] = opnd(a) & opnd(b);
            endcase
            ef = flg(regs[0]);
        end
        base = done_cnt;
        i_host.cmd(o, a, b, 1'b0, 32'h0);
        wait_done(base + 1);
        i_host.rd(`RLMU_OFS_ACC, rv);
        chk(rv, regs[0], "accumulator");
        chk({27'h0, cond_flags_ff}, {27'h0, ef}, "flags");
    end
    endtask
    task automatic print_verdict;
    begin
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // Watchdog: the tests need under a thousand cycles, this allows 30000
    initial
    begin
        #300000;
        mismatches++;
        print_verdict;
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        ef = 5'h00;
        for (i = 0; i < 32; i++)
            regs[i] = 32'h0;
        rv = $urandom(42);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 1; i < 28; i++)
        begin
            rv = (i >= 16) ? 32'($urandom_range(65534)) - 32'h7FFF : $urandom;
            load(5'(i), 1'b1, rv);
            load(5'(i), 1'b0, 32'h0);
        end
        $display("test loads done");
        load(5'h1D, 1'b1, $urandom);
        i_host.rd(`RLMU_OFS_STATUS, rv);
        chk({31'h0, rv[`RLMU_ST_RO_ERR_BIT]}, 32'h1, "read-only refusal");
        load(5'h1D, 1'b0, 32'h0);
        $display("test read-only done");
        // Out-of-range long value: refused, register kept, errors clear on write
        i_host.wr(`RLMU_OFS_STATUS, 32'h00000018);
        base = done_cnt;
        i_host.wr(`RLMU_OFS_VALUE, `RLMU_LONG_ILLEGAL);
        i_host.wr(`RLMU_OFS_CMD, 32'h01000100);
        wait_done(base + 1);
        i_host.rd(`RLMU_OFS_STATUS, rv);
        chk(32'(rv[`RLMU_ST_RO_ERR_BIT:`RLMU_ST_RANGE_ERR_BIT]), 32'h1, "range refusal");
        load(5'h01, 1'b0, 32'h0);
        $display("test range done");
        load(5'h01, 1'b1, 32'h7FFFFFFF);
        load(5'h02, 1'b1, 32'h00000001);
        do_math(`RLMU_OP_ADD, 5'h01, 5'h02);
        do_math(`RLMU_OP_DIV, 5'h01, 5'h1E);
        do_math(`RLMU_OP_SUB, 5'h00, 5'h00);
        base = done_cnt;
        i_host.cmd(`RLMU_OP_LOAD, 5'h03, 5'h00, 1'b1, 32'h0000F0F0);
        i_host.cmd(`RLMU_OP_LOAD, 5'h04, 5'h00, 1'b1, 32'h00FF00FF);
        i_host.cmd(`RLMU_OP_AND, 5'h03, 5'h04, 1'b0, 32'h0);
        wait_done(base + 3);
        i_host.rd(`RLMU_OFS_ACC, rv);
        chk(rv, 32'h000000F0, "queued and");
        regs[3] = 32'h0000F0F0;
        regs[4] = 32'h00FF00FF;
        regs[0] = 32'h000000F0;
        ef = flg(32'h000000F0);
        chk({27'h0, cond_flags_ff}, {27'h0, ef}, "queued flags");
        // Unused opcode retires without touching accumulator or flags
        base = done_cnt;
        i_host.cmd(3'h6, 5'h01, 5'h02, 1'b0, 32'h0);
        wait_done(base + 1);
        i_host.rd(`RLMU_OFS_ACC, rv);
        chk(rv, regs[0], "unused opcode");
        chk({27'h0, cond_flags_ff}, {27'h0, ef}, "unused opcode flags");
        $display("test corners done");
        for (i = 0; i < 60; i++)
            do_math(3'($urandom_range(5, 1)), 5'($urandom_range(31, 1)), 5'($urandom_range(31, 1)));
        $display("test random math done");
        print_verdict;
    end
endmodule // rlmu_core_tb_top
`default_nettype wire

// ===== rlmu_defines.vh
// Register offsets, field positions, opcodes and reset values for the load/math unit
`ifndef RLMU_DEFINES_VH
`define RLMU_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RLMU_OFS_VALUE 8'h00
`define RLMU_OFS_CMD 8'h04
`define RLMU_OFS_STATUS 8'h08
`define RLMU_OFS_READBACK 8'h0C
`define RLMU_OFS_ACC 8'h10

// ----------------------------------------
// Command word fields
// ----------------------------------------
`define RLMU_CMD_OP_LSB 0
`define RLMU_CMD_OP_MSB 2
`define RLMU_CMD_A_LSB 8
`define RLMU_CMD_A_MSB 12
`define RLMU_CMD_B_LSB 16
`define RLMU_CMD_B_MSB 20
`define RLMU_CMD_HASVAL_BIT 24

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define RLMU_OP_LOAD 3'h0
`define RLMU_OP_ADD 3'h1
`define RLMU_OP_SUB 3'h2
`define RLMU_OP_MUL 3'h3
`define RLMU_OP_DIV 3'h4
`define RLMU_OP_AND 3'h5

// ----------------------------------------
// Status bits
// ----------------------------------------
`define RLMU_ST_EMPTY_BIT 0
`define RLMU_ST_FULL_BIT 1
`define RLMU_ST_RBVALID_BIT 2
`define RLMU_ST_RANGE_ERR_BIT 3
`define RLMU_ST_RO_ERR_BIT 4
`define RLMU_ST_OVFL_BIT 5
`define RLMU_ST_CC_LSB 8
`define RLMU_ST_CC_MSB 12

// ----------------------------------------
// Condition flag positions and constants
// ----------------------------------------
`define RLMU_CC_Z 0
`define RLMU_CC_P 1
`define RLMU_CC_N 2
`define RLMU_CC_F 3
`define RLMU_CC_T 4
`define RLMU_ACC_IDX 5'h00
`define RLMU_LONG_ILLEGAL 32'h80000000
`define RLMU_ZERO32 32'h00000000
`define RLMU_CC_RESET 5'h00

`endif

// ===== rlmu_host_model.sv
// Host model issuing register accesses and buffered commands
`timescale 1ns/1ps
`default_nettype none
`include "rlmu_defines.vh"
module rlmu_host_model (
    // Clock
    input wire logic core_clk,
    // Register port toward the unit
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [31:0] rdata_ff
);
    // Idle bus at time zero
    initial
    begin
        addr = 8'hFF;
        wdata = 32'h00000000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // One-cycle write; lines scrambled after so stale values never help
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    end
    endtask
    // One-cycle read; data taken in the one cycle they stand
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
    begin
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata_ff;
    end
    endtask
    // Buffered command: stage value, then push the command word
    task automatic cmd(input logic [2:0] op, input logic [4:0] ra, input logic [4:0] rb,
        input logic hv, input logic [31:0] v);
    begin
        wr(`RLMU_OFS_VALUE, (v == `RLMU_LONG_ILLEGAL) ? 32'h80000001 : v);
        wr(`RLMU_OFS_CMD, {7'h00, hv, 3'h0, rb, 3'h0, ra, 5'h00, op});
    end
    endtask
endmodule // rlmu_host_model
`default_nettype wire
